// ### core/tkh_params.svh
// constants of the toolkit command and status handler
`ifndef TKH_PARAMS_SVH
`define TKH_PARAMS_SVH

// instruction codes seen in the command header
`define TKH_INS_PROFILE   8'h10
`define TKH_INS_ENVELOPE  8'hc2
`define TKH_INS_FETCH     8'h12
`define TKH_INS_TRESP     8'h14
`define TKH_INS_GETRESP   8'hc0
`define TKH_INS_RDREC     8'hb2
`define TKH_INS_UPDREC    8'hdc

// record addressing modes in the second parameter byte
`define TKH_RMODE_NEXT    8'h02
`define TKH_RMODE_PREV    8'h03
`define TKH_RMODE_ABS     8'h04

// status words, first status bytes and the null byte
`define TKH_SW_OK         16'h9000
`define TKH_SW_BUSY       16'h9300
`define TKH_SW_TECH       16'h6f00
`define TKH_SW_INS_BAD    16'h6d00
`define TKH_SW_COND       16'h6985
`define TKH_SW1_PEND      8'h91
`define TKH_SW1_BUSY      8'h93
`define TKH_SW1_DLERR     8'h9e
`define TKH_NULL_BYTE     8'h60

// header field positions in the 40-bit header word (class first)
`define TKH_HDR_INS_LSB   24
`define TKH_HDR_P1_LSB    16
`define TKH_HDR_P2_LSB    8

// timing: null byte spacing while the answer is not ready
`define TKH_CLK_MHZ       100
`define TKH_NULL_NS       5000
`define TKH_NULL_CYC      ((`TKH_NULL_NS * `TKH_CLK_MHZ) / 1000)

`endif

// ### core/tkh_pkg.sv
// types of the toolkit command and status handler
`default_nettype none
package tkh_pkg;
    typedef enum logic [1:0] {
        TK_IDLE  = 2'b00,
        TK_READY = 2'b01,
        TK_PEND  = 2'b10,
        TK_DLERR = 2'b11
    } tkh_tk_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_WAIT  = 2'b01,
        PH_SEND  = 2'b10,
        PH_DRAIN = 2'b11
    } tkh_ph_t;

    typedef enum logic [1:0] {
        RES_OK    = 2'b00,
        RES_BUSY  = 2'b01,
        RES_DLERR = 2'b10,
        RES_FAIL  = 2'b11
    } tkh_res_t;
endpackage
`default_nettype wire

// ### core/tkh_if.sv
// crossing bundle between the system-side handler and the link-side framer
`default_nettype none
interface tkh_if;
    logic [39:0] hdr;
    logic        hdr_tgl;
    logic [15:0] tx_word;
    logic        tx_two;
    logic        tx_tgl;
    logic        tx_ack_tgl;

    modport sys  (input hdr, hdr_tgl, tx_ack_tgl, output tx_word, tx_two, tx_tgl);
    modport link (output hdr, hdr_tgl, tx_ack_tgl, input tx_word, tx_two, tx_tgl);
endinterface
`default_nettype wire

// ### core/tkh_sync.sv
// two-flop level synchroniser, one per bit
`default_nettype none
module tkh_sync
    import tkh_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset of the receiving domain
    input  wire logic         clk,
    input  wire logic         rst_b,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] a;
        logic [W-1:0] b;
    } tkh_sync_st_t;

    tkh_sync_st_t s_r;
    tkh_sync_st_t s_nxt;

    if (W < 1) begin : g_bad_width
        $error("tkh_sync width must be positive");
    end

    always_comb begin
        s_nxt   = s_r;
        s_nxt.a = d;
        s_nxt.b = s_r.a;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.b;
endmodule
`default_nettype wire

// ### core/tkh_link.sv
// link-side framer: gathers header bytes, plays out null and status bytes
`default_nettype none
`include "tkh_params.svh"
module tkh_link
    import tkh_pkg::*;
(
    // link clock domain
    input  wire logic clk_link,
    input  wire logic rst_b,
    // byte stream from and to the line
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_byte,
    output logic            tx_valid,
    output logic [7:0]      tx_byte,
    input  wire logic       tx_ready,
    // crossing bundle
    tkh_if.link             xb
);
    typedef struct packed {
        logic [2:0]  cnt;
        logic [39:0] hdr;
        logic        hdr_tgl;
        logic        open;
        logic        tx_seen;
        logic        tx_valid;
        logic [7:0]  tx_byte;
        logic        second;
        logic        is_stat;
        logic        ack_tgl;
    } tkh_link_st_t;

    tkh_link_st_t s_r;
    tkh_link_st_t s_nxt;
    logic         tx_tgl_s;

    tkh_sync #(.W(1)) u_tx_sync (
        .clk   (clk_link),
        .rst_b (rst_b),
        .d     (xb.tx_tgl),
        .q     (tx_tgl_s)
    );

    always_comb begin
        s_nxt = s_r;
        // header bytes are ignored while a transaction is open
        if (rx_valid && !s_r.open) begin
            s_nxt.hdr = {s_r.hdr[31:0], rx_byte};
            if (s_r.cnt == 3'h4) begin
                s_nxt.cnt     = 3'h0;
                s_nxt.open    = 1'b1;
                s_nxt.hdr_tgl = ~s_r.hdr_tgl;
            end else begin
                s_nxt.cnt = s_r.cnt + 3'h1;
            end
        end
        if (s_r.tx_valid && tx_ready) begin
            if (s_r.second) begin
                s_nxt.tx_byte = xb.tx_word[7:0];
                s_nxt.second  = 1'b0;
            end else begin
                s_nxt.tx_valid = 1'b0;
                s_nxt.ack_tgl  = ~s_r.ack_tgl;
                // the status word closes the transaction
                if (s_r.is_stat) s_nxt.open = 1'b0;
            end
        end else if (!s_r.tx_valid && tx_tgl_s != s_r.tx_seen) begin
            s_nxt.tx_seen  = tx_tgl_s;
            s_nxt.tx_valid = 1'b1;
            s_nxt.second   = xb.tx_two;
            s_nxt.is_stat  = xb.tx_two;
            s_nxt.tx_byte  = xb.tx_two ? xb.tx_word[15:8] : xb.tx_word[7:0];
        end
    end

    always_ff @(posedge clk_link or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_valid      = s_r.tx_valid;
    assign tx_byte       = s_r.tx_byte;
    assign xb.hdr        = s_r.hdr;
    assign xb.hdr_tgl    = s_r.hdr_tgl;
    assign xb.tx_ack_tgl = s_r.ack_tgl;
endmodule
`default_nettype wire

// ### core/tkh_handler.sv
// toolkit command and status handler, card side, top level
`default_nettype none
`include "tkh_params.svh"
module tkh_handler
    import tkh_pkg::*;
#(
    parameter int NULL_CYC = `TKH_NULL_CYC
) (
    // clocks and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       clk_link,
    // line byte stream, link clock domain
    input  wire logic       lnk_rx_valid,
    input  wire logic [7:0] lnk_rx_byte,
    output logic            lnk_tx_valid,
    output logic [7:0]      lnk_tx_byte,
    input  wire logic       lnk_tx_ready,
    // card configuration
    input  wire logic       card_tk_en,
    // command dispatch to the card operating code
    output logic            app_cmd_valid,
    output logic [39:0]     app_cmd_hdr,
    output logic            app_cmd_tk,
    input  wire logic       app_done,
    input  wire tkh_res_t   app_res,
    input  wire logic [7:0] app_len,
    input  wire logic       app_prof_dlerr,
    input  wire logic [7:0] app_pro_len,
    // ordinary file selection
    input  wire logic       norm_sel_valid,
    input  wire logic [15:0] norm_sel_ef,
    output logic [15:0]     sel_ef,
    output logic [7:0]      rec_ptr,
    // observed state
    output tkh_tk_t         tk_state,
    output logic            me_tk,
    output logic            me_dlerr_cap,
    output logic [15:0]     sw_last
);
    typedef struct packed {
        tkh_tk_t     st;
        tkh_ph_t     ph;
        logic        hdr_seen;
        logic [39:0] hdr;
        logic        cmd_tk;
        logic        cmd_valid;
        logic        me_tk;
        logic        me_dlerr;
        logic [15:0] sel_ef;
        logic [7:0]  rec_ptr;
        logic [15:0] sw;
        logic [15:0] tx_word;
        logic        tx_two;
        logic        tx_tgl;
        logic [15:0] null_cnt;
    } tkh_st_t;

    tkh_st_t    s_r;
    tkh_st_t    s_nxt;
    tkh_if      xb ();
    logic [1:0] sync_q;
    logic       hdr_tgl_s;
    logic       ack_s;

    // the wait counter is 16 bits wide
    if (NULL_CYC < 1 || NULL_CYC > 65535) begin : g_bad_null
        $error("NULL_CYC out of range");
    end

    tkh_link u_link (
        .clk_link (clk_link),
        .rst_b    (rst_b),
        .rx_valid (lnk_rx_valid),
        .rx_byte  (lnk_rx_byte),
        .tx_valid (lnk_tx_valid),
        .tx_byte  (lnk_tx_byte),
        .tx_ready (lnk_tx_ready),
        .xb       (xb.link)
    );

    // header word is held by the link side until the status is sent, so only toggles sync
    tkh_sync #(.W(2)) u_sys_sync (
        .clk   (clk_sys),
        .rst_b (rst_b),
        .d     ({xb.hdr_tgl, xb.tx_ack_tgl}),
        .q     (sync_q)
    );
    assign hdr_tgl_s = sync_q[1];
    assign ack_s     = sync_q[0];

    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic       new_hdr;
    logic       tx_idle;
    logic       ins_tk;
    logic       tk_ok;
    assign ins     = s_r.hdr[`TKH_HDR_INS_LSB +: 8];
    assign p1      = s_r.hdr[`TKH_HDR_P1_LSB +: 8];
    assign p2      = s_r.hdr[`TKH_HDR_P2_LSB +: 8];
    assign new_hdr = hdr_tgl_s != s_r.hdr_seen;
    assign tx_idle = ack_s == s_r.tx_tgl;
    assign tk_ok   = card_tk_en && s_r.me_tk;

    function automatic logic is_tk(input logic [7:0] i);
        is_tk = (i == `TKH_INS_PROFILE) || (i == `TKH_INS_ENVELOPE) ||
                (i == `TKH_INS_FETCH) || (i == `TKH_INS_TRESP);
    endfunction
    assign ins_tk = is_tk(ins);

    always_comb begin
        logic [7:0] hins;
        logic [15:0] sw;
        hins  = xb.hdr[`TKH_HDR_INS_LSB +: 8];
        sw    = `TKH_SW_OK;
        s_nxt = s_r;
        s_nxt.cmd_valid = 1'b0;
        // a header that lands while the status drains stays pending until idle
        case (s_r.ph)
            PH_IDLE: begin
                // link ignores further header bytes until the status goes out
                if (new_hdr) begin
                    s_nxt.hdr_seen = hdr_tgl_s;
                    s_nxt.hdr    = xb.hdr;
                    s_nxt.cmd_tk = is_tk(hins);
                    if (is_tk(hins) && !card_tk_en) begin
                        s_nxt.sw = `TKH_SW_INS_BAD;
                        s_nxt.ph = PH_SEND;
                    end else if (is_tk(hins) && hins != `TKH_INS_PROFILE && !s_r.me_tk) begin
                        s_nxt.sw = `TKH_SW_INS_BAD;
                        s_nxt.ph = PH_SEND;
                    end else if (hins == `TKH_INS_FETCH && s_r.st != TK_PEND) begin
                        s_nxt.sw = `TKH_SW_COND;
                        s_nxt.ph = PH_SEND;
                    end else begin
                        // tag-driven processing of the data is the operating code's job
                        s_nxt.cmd_valid = 1'b1;
                        s_nxt.null_cnt  = '0;
                        s_nxt.ph        = PH_WAIT;
                    end
                end
            end
            PH_WAIT: begin
                if (app_done) begin
                    case (app_res)
                        RES_BUSY: begin
                            // busy only for envelopes, no state touched
                            sw = (ins == `TKH_INS_ENVELOPE && tk_ok) ? `TKH_SW_BUSY
                                                                     : `TKH_SW_TECH;
                        end
                        RES_DLERR: begin
                            if (ins == `TKH_INS_ENVELOPE && tk_ok && s_r.me_dlerr) begin
                                sw       = {`TKH_SW1_DLERR, app_len};
                                s_nxt.st = TK_DLERR;
                            end else begin
                                sw = `TKH_SW_TECH;
                            end
                        end
                        RES_FAIL: begin
                            sw = `TKH_SW_TECH;
                        end
                        default: begin
                            // apart from pending data and a get-response in the download-error state, ordinary pairs leave the task state
                            if (ins == `TKH_INS_PROFILE) begin
                                s_nxt.me_tk    = 1'b1;
                                s_nxt.me_dlerr = app_prof_dlerr;
                                s_nxt.st       = TK_READY;
                            end else if (ins == `TKH_INS_FETCH || ins == `TKH_INS_TRESP) begin
                                s_nxt.st = TK_READY;
                            end else if (ins == `TKH_INS_GETRESP && s_r.st == TK_DLERR) begin
                                s_nxt.st = TK_READY;
                            end else if (!ins_tk &&
                                         (ins == `TKH_INS_RDREC || ins == `TKH_INS_UPDREC)) begin
                                // only ordinary record commands move the pointer
                                if (p2 == `TKH_RMODE_NEXT) begin
                                    s_nxt.rec_ptr = s_r.rec_ptr + 8'h01;
                                end else if (p2 == `TKH_RMODE_PREV) begin
                                    s_nxt.rec_ptr = s_r.rec_ptr - 8'h01;
                                end else if (p2 == `TKH_RMODE_ABS) begin
                                    s_nxt.rec_ptr = p1;
                                end
                            end
                            // pending data is flagged on any pair answered OK outside the download-error state once both sides have toolkit, which is what polling needs
                            if (card_tk_en && s_nxt.me_tk && app_pro_len != 8'h00 &&
                                s_nxt.st != TK_DLERR) begin
                                sw       = {`TKH_SW1_PEND, app_pro_len};
                                s_nxt.st = TK_PEND;
                            end
                        end
                    endcase
                    s_nxt.sw = sw;
                    s_nxt.ph = PH_SEND;
                end else if (s_r.null_cnt >= 16'(NULL_CYC - 1)) begin
                    // a stall byte keeps the line waiting but does not close the transaction
                    if (tx_idle) begin
                        s_nxt.tx_word  = {8'h00, `TKH_NULL_BYTE};
                        s_nxt.tx_two   = 1'b0;
                        s_nxt.tx_tgl   = ~s_r.tx_tgl;
                        s_nxt.null_cnt = '0;
                    end
                end else begin
                    s_nxt.null_cnt = s_r.null_cnt + 16'h0001;
                end
            end
            PH_SEND: begin
                if (tx_idle) begin
                    s_nxt.tx_word = s_r.sw;
                    s_nxt.tx_two  = 1'b1;
                    s_nxt.tx_tgl  = ~s_r.tx_tgl;
                    s_nxt.ph      = PH_DRAIN;
                end
            end
            default: begin
                // the card ends the pair once both status bytes are out
                if (tx_idle) s_nxt.ph = PH_IDLE;
            end
        endcase
        if (norm_sel_valid) begin
            s_nxt.sel_ef  = norm_sel_ef;
            s_nxt.rec_ptr = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign xb.tx_word    = s_r.tx_word;
    assign xb.tx_two     = s_r.tx_two;
    assign xb.tx_tgl     = s_r.tx_tgl;
    assign app_cmd_valid = s_r.cmd_valid;
    assign app_cmd_hdr   = s_r.hdr;
    assign app_cmd_tk    = s_r.cmd_tk;
    assign sel_ef        = s_r.sel_ef;
    assign rec_ptr       = s_r.rec_ptr;
    assign tk_state      = s_r.st;
    assign me_tk         = s_r.me_tk;
    assign me_dlerr_cap  = s_r.me_dlerr;
    assign sw_last       = s_r.sw;

    AST_TK_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.cmd_valid && s_r.cmd_tk) |-> card_tk_en &&
        (s_r.me_tk || ins == `TKH_INS_PROFILE))
        else $error("toolkit command dispatched without capability");

    AST_TK_SW_BOTH: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($changed(s_r.tx_tgl) && s_r.tx_two && (s_r.tx_word[15:8] == `TKH_SW1_PEND ||
         s_r.tx_word[15:8] == `TKH_SW1_BUSY || s_r.tx_word[15:8] == `TKH_SW1_DLERR))
        |-> s_r.me_tk)
        else $error("toolkit status sent to a terminal without toolkit");

    AST_DLERR_CAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.ph == PH_SEND && s_r.sw[15:8] == `TKH_SW1_DLERR) |->
        s_r.me_dlerr && s_r.st == TK_DLERR)
        else $error("download error status without declared support");

    AST_BUSY_ENV: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.ph == PH_SEND && s_r.sw == `TKH_SW_BUSY) |->
        ins == `TKH_INS_ENVELOPE && $stable(s_r.st) && $stable(s_r.rec_ptr))
        else $error("busy status outside an envelope or with state change");

    AST_FILE_KEPT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.ph == PH_WAIT && app_done && s_r.cmd_tk && !norm_sel_valid) |=>
        $stable(s_r.rec_ptr) && $stable(s_r.sel_ef))
        else $error("toolkit pair moved the ordinary file state");

    AST_TK_STATE_KEPT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.ph == PH_WAIT && app_done && !s_r.cmd_tk && app_pro_len == 8'h00 &&
         ins != `TKH_INS_GETRESP) |=> $stable(s_r.st))
        else $error("ordinary pair changed toolkit task state");

    AST_ONE_TXN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_r.cmd_valid |-> ##1 (s_r.ph != PH_IDLE && !s_r.cmd_valid)[*2])
        else $error("second command accepted inside a transaction");

    AST_NULL_ONLY_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($changed(s_r.tx_tgl) && !s_r.tx_two) |->
        s_r.tx_word[7:0] == `TKH_NULL_BYTE && $past(s_r.ph) == PH_WAIT)
        else $error("null byte outside the wait for an answer");

    AST_LEN_BYTE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.ph == PH_WAIT && app_done && app_res == RES_OK && !$past(app_done) &&
         s_nxt.sw[15:8] == `TKH_SW1_PEND) |=> s_r.sw[7:0] == $past(app_pro_len))
        else $error("pending status length byte wrong");

    AST_FETCH_PEND: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.cmd_valid && ins == `TKH_INS_FETCH) |-> $past(s_r.st) == TK_PEND)
        else $error("fetch dispatched with nothing pending");

    AST_HDR_IN_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.hdr_seen != $past(s_r.hdr_seen)) |->
        $past(s_r.ph) == PH_IDLE && s_r.hdr == $past(xb.hdr))
        else $error("header taken while a transaction was open");

    AST_REFUSE_TK: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.ph == PH_IDLE && new_hdr && !card_tk_en &&
         is_tk(xb.hdr[`TKH_HDR_INS_LSB +: 8])) |=>
        !s_r.cmd_valid && s_r.sw == `TKH_SW_INS_BAD && s_r.ph == PH_SEND)
        else $error("toolkit command taken by a card without toolkit");

    AST_TK_SW_CARD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.ph == PH_SEND && (s_r.sw[15:8] == `TKH_SW1_PEND ||
         s_r.sw[15:8] == `TKH_SW1_BUSY || s_r.sw[15:8] == `TKH_SW1_DLERR)) |->
        card_tk_en && s_r.me_tk)
        else $error("toolkit status chosen without toolkit on both sides");

    AST_PEND_STATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_r.ph == PH_SEND && s_r.sw[15:8] == `TKH_SW1_PEND) |-> s_r.st == TK_PEND)
        else $error("pending status without pending task state");

    AST_NULL_SPACING: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($changed(s_r.tx_tgl) && !s_r.tx_two) |-> $past(s_r.null_cnt) >= 16'(NULL_CYC - 1))
        else $error("null byte sent before the wait interval ran out");

    AST_ME_TK_PROFILE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(s_r.me_tk) |-> ins == `TKH_INS_PROFILE && s_r.ph == PH_SEND)
        else $error("terminal toolkit flag set outside a profile");

    AST_SEL_TAKEN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        norm_sel_valid |=> s_r.sel_ef == $past(norm_sel_ef) && s_r.rec_ptr == 8'h00)
        else $error("ordinary selection not taken as given");
endmodule
`default_nettype wire

// ### tb/tkh_me_model.sv
// behavioural terminal: sends command headers, takes null and status bytes
`default_nettype none
module tkh_me_model (
    // link clock
    input  wire logic       clk_link,
    // header bytes to the card
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    // bytes from the card
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h5a;
        tx_ready = 1'b0;
    end
    // returns once the second status byte was taken, or after 4000 link cycles, so a new
    // header does not overlap an open transaction unless that limit runs out
    task automatic xact(input logic [7:0] ins, p1, input int stall,
                        output logic [15:0] sw, output int nulls);
        logic [39:0] h;
        logic        v;
        int          got;
        // second parameter repeats the first so record commands pick a mode
        h = {8'ha0, ins, p1, p1, 8'h00};
        got = 0;
        nulls = 0;
        sw = 16'h0000;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_link);
            #0.5;
            rx_valid = 1'b1;
            rx_byte = h[39-8*k -: 8];
        end
        for (int k = 0; k < 4000 && got < 2; k++) begin
            @(posedge clk_link);
            #0.5;
            rx_valid = 1'b0;
            // released line must not keep showing the last header byte
            rx_byte = ~rx_byte;
            tx_ready = (stall == 0) || (k % 3 == 2);
            // mid-cycle sample avoids racing the card's own edge updates
            @(negedge clk_link);
            v = (tx_valid === 1'b1) && (tx_ready === 1'b1);
            if (v && got == 0 && tx_byte === 8'h60)
                nulls++;
            else if (v) begin
                sw = {sw[7:0], tx_byte};
                got++;
            end
        end
        @(posedge clk_link);
        #0.5;
        tx_ready = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/tkh_handler_tb.sv
// self-checking bench of the toolkit command and status handler
`default_nettype none
module tkh_handler_tb import tkh_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys, clk_link, rst_b, rx_valid, tx_valid, tx_ready, card_tk_en;
    logic        app_cmd_valid, app_cmd_tk, app_done, prof_dlerr, sel_valid;
    logic        me_tk, me_dlerr_cap, last_tk;
    logic [7:0]  rx_byte, tx_byte, app_len, pro_len, rec_ptr;
    logic [15:0] sel_in, sel_ef, sw_last, sw;
    logic [39:0] app_cmd_hdr, last_hdr;
    tkh_res_t    res;
    tkh_tk_t     tk_state;
    int          failures, n_checks, n_disp, lat, nl;

    tkh_handler #(.NULL_CYC(8)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_link(clk_link),
        .lnk_rx_valid(rx_valid), .lnk_rx_byte(rx_byte), .lnk_tx_valid(tx_valid),
        .lnk_tx_byte(tx_byte), .lnk_tx_ready(tx_ready), .card_tk_en(card_tk_en),
        .app_cmd_valid(app_cmd_valid), .app_cmd_hdr(app_cmd_hdr), .app_cmd_tk(app_cmd_tk),
        .app_done(app_done), .app_res(res), .app_len(app_len), .app_prof_dlerr(prof_dlerr),
        .app_pro_len(pro_len), .norm_sel_valid(sel_valid), .norm_sel_ef(sel_in),
        .sel_ef(sel_ef), .rec_ptr(rec_ptr), .tk_state(tk_state), .me_tk(me_tk),
        .me_dlerr_cap(me_dlerr_cap), .sw_last(sw_last));
    tkh_me_model me (.clk_link(clk_link), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

    always #5 clk_sys = ~clk_sys;
    initial begin
        clk_link = 1'b0;
        #1.3;
        forever #3 clk_link = ~clk_link;
    end
    // operating-code stand-in: answers each dispatch after lat cycles
    initial begin
        app_done = 1'b0;
        forever begin
            @(posedge clk_sys);
            #1;
            if (app_cmd_valid === 1'b1) begin
                n_disp++;
                last_tk = app_cmd_tk;
                last_hdr = app_cmd_hdr;
                repeat (lat) @(posedge clk_sys);
                #2 app_done = 1'b1;
                @(posedge clk_sys);
                #2 app_done = 1'b0;
            end
        end
    end
    task automatic chk(input logic [39:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] ins, p1, input int stall);
        me.xact(ins, p1, stall, sw, nl);
        repeat (6) @(posedge clk_sys);
        #2;
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_nocap;
        int d;
        d = n_disp;
        cmd(8'h10, 8'h01, 0);
        chk(sw, 16'h6d00);
        card_tk_en = 1'b1;
        cmd(8'hc2, 8'h01, 0);
        chk(sw, 16'h6d00);
        chk(n_disp, d);
        pro_len = 8'h05;
        cmd(8'hb2, 8'h01, 0);
        chk(sw, 16'h9000);
        chk(sw_last, 16'h9000);
        pro_len = 8'h00;
    endtask
    task automatic t_profile;
        sel_in = 16'h6f3a;
        sel_valid = 1'b1;
        @(posedge clk_sys);
        #2 sel_valid = 1'b0;
        @(posedge clk_sys);
        #2 chk({sel_ef, rec_ptr}, 24'h6f3a00);
        cmd(8'h10, 8'h01, 0);
        chk(sw, 16'h9000);
        chk({last_tk, me_tk, me_dlerr_cap}, 3'b110);
        chk(last_hdr, 40'ha010010100);
    endtask
    task automatic t_busy;
        res = RES_BUSY;
        cmd(8'hc2, 8'h02, 0);
        chk(sw, 16'h9300);
        chk(sel_ef, 16'h6f3a);
        cmd(8'h14, 8'h03, 0);
        chk(sw, 16'h6f00);
        res = RES_OK;
        cmd(8'hc2, 8'h02, 0);
        chk(sw, 16'h9000);
        chk(last_tk, 1'b1);
    endtask
    task automatic t_dlerr;
        res = RES_DLERR;
        app_len = 8'h12;
        cmd(8'hc2, 8'h04, 0);
        chk(sw, 16'h6f00);
        res = RES_OK;
        prof_dlerr = 1'b1;
        cmd(8'h10, 8'h01, 1);
        chk(me_dlerr_cap, 1'b1);
        res = RES_DLERR;
        cmd(8'hc2, 8'h04, 0);
        chk({sw, tk_state}, {16'h9e12, TK_DLERR});
        res = RES_OK;
        cmd(8'hc0, 8'h00, 0);
        chk(tk_state, TK_READY);
    endtask
    task automatic t_pend;
        pro_len = 8'h05;
        cmd(8'hc2, 8'h05, 0);
        chk({sw, tk_state}, {16'h9105, TK_PEND});
        cmd(8'hb2, 8'h04, 0);
        chk({sw, tk_state}, {16'h9105, TK_PEND});
        chk(rec_ptr, 8'h04);
        chk(sel_ef, 16'h6f3a);
        pro_len = 8'h00;
        cmd(8'h12, 8'h00, 1);
        chk({last_tk, tk_state}, {1'b1, TK_READY});
        chk(rec_ptr, 8'h04);
        cmd(8'hdc, 8'h02, 0);
        chk({sw, rec_ptr, tk_state}, {16'h9000, 8'h05, TK_READY});
        cmd(8'h12, 8'h00, 0);
        chk(sw, 16'h6985);
    endtask
    task automatic t_null;
        lat = 60;
        cmd(8'hc2, 8'h06, 1);
        chk(nl > 0, 1'b1);
        chk(sw, 16'h9000);
        lat = 2;
    endtask
    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        {card_tk_en, prof_dlerr, sel_valid} = 3'b000;
        {app_len, pro_len, sel_in} = 32'h0000_0000;
        res = RES_OK;
        {failures, n_checks, n_disp, lat} = {32'd0, 32'd0, 32'd0, 32'd2};
        repeat (2) @(posedge clk_sys);
        #2 rst_b = 1'b1;
        repeat (3) @(posedge clk_sys);
        #2;
        t_nocap;
        t_profile;
        t_busy;
        t_dlerr;
        t_pend;
        t_null;
        complete_run;
    end
    initial begin
        #100us;
        failures++;
        complete_run;
    end
endmodule
`default_nettype wire
